// file: src/arith_map.svh
`ifndef ARITH_MAP_SVH
`define ARITH_MAP_SVH

// word layout: sign, exponent sign, exponent magnitude, mantissa fraction
`define SIGN_BIT       47
`define MAG_RANGE      46:0
`define EXP_RANGE      46:35
`define EXP_SIGN_BIT   46
`define EXP_MAG_RANGE  45:35
`define MANT_RANGE     34:0
`define MANT_MSB       34

// exponent limits and constants
`define EXP_MAX        14'sh7ff
`define EXP_MIN        (-14'sh7ff)
`define EXP_ONE        14'sh001
`define FLT_EXP_BASE   14'sh02f
`define ALIGN_LIMIT    14'sh024
`define EXP_MAG_LIMIT  12'h7ff

// floating zero: negative all-ones exponent, positive zero mantissa
`define FLOAT_ZERO     48'h7ff800000000

// operation codes (octal 65, 64, 61, 60, 25, 66, 63, 62)
`define OP_FIXED_ADD   6'h35
`define OP_FIXED_SUB   6'h34
`define OP_FIXED_MUL   6'h31
`define OP_FIXED_DIV   6'h30
`define OP_BIN_TO_FLT  6'h15
`define OP_FLOAT_SUB   6'h36
`define OP_FLOAT_MUL   6'h33
`define OP_FLOAT_DIV   6'h32

// divider step counts: 47 fraction bits fixed, 35 floating
`define FIX_DIV_STEPS  6'h2f
`define FLT_DIV_STEPS  6'h23

`endif

// file: src/arith_pkg.sv
package arith_pkg;

   typedef enum logic [1:0] {
      ST_IDLE   = 2'b01,
      ST_DIVIDE = 2'b10
   } unit_state_type;

   typedef struct packed {
      logic [47:0] result;
      logic [47:0] scratch;
      logic        result_we;
      logic        scratch_we;
      logic        ovf;
      logic        unf;
      logic        nonnorm;
      logic        go_divide;
   } calc_type;

   typedef struct packed {
      unit_state_type state;
      logic [5:0]     op;
      logic [47:0]    a;
      logic [47:0]    b;
      logic [47:0]    result;
      logic [47:0]    scratch;
      logic           result_we;
      logic           scratch_we;
      logic           done;
      logic           ovf;
      logic           unf;
      logic           nonnorm;
   } unit_regs_type;

   typedef struct packed {
      logic        busy;
      logic        done;
      logic [5:0]  count;
      logic [47:0] rem;
      logic [46:0] divisor;
      logic [46:0] quo;
      logic        int_bit;
   } div_regs_type;

endpackage

// file: src/seq_divider.sv
`timescale 1ns/1ps
module seq_divider
   import arith_pkg::*;
(
   input  wire logic        i_core_clk,
   input  wire logic        i_rst,
   input  wire logic        i_start,
   input  wire logic [46:0] i_dividend,
   input  wire logic [46:0] i_divisor,
   input  wire logic [5:0]  i_steps,
   output logic             o_busy,
   output logic             o_done,
   output logic [46:0]      o_quotient,
   output logic             o_int_bit,
   output logic [46:0]      o_remainder
);

   div_regs_type r_q;
   div_regs_type r_d;

   // restoring division, one quotient bit per clock; the integer bit is
   // taken before the first shift, further overflow bits are lost
   always_comb begin
      logic [47:0] shifted;
      shifted = '0;
      r_d = r_q;
      r_d.done = 1'b0;
      if (i_start && !r_q.busy) begin
         r_d.busy = 1'b1;
         r_d.count = i_steps;
         r_d.divisor = i_divisor;
         r_d.quo = '0;
         r_d.int_bit = (i_dividend >= i_divisor);
         r_d.rem = r_d.int_bit ? {1'b0, i_dividend - i_divisor} : {1'b0, i_dividend};
      end else if (r_q.busy) begin
         shifted = {r_q.rem[46:0], 1'b0};
         if (shifted >= {1'b0, r_q.divisor}) begin
            r_d.rem = shifted - {1'b0, r_q.divisor};
            r_d.quo = {r_q.quo[45:0], 1'b1};
         end else begin
            r_d.rem = shifted;
            r_d.quo = {r_q.quo[45:0], 1'b0};
         end
         r_d.count = r_q.count - 6'h01;
         if (r_q.count == 6'h01) begin
            r_d.busy = 1'b0;
            r_d.done = 1'b1;
         end
      end
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         r_q <= '0;
      end else begin
         r_q <= r_d;
      end
   end

   assign o_busy      = r_q.busy;
   assign o_done      = r_q.done;
   assign o_quotient  = r_q.quo;
   assign o_int_bit   = r_q.int_bit;
   assign o_remainder = r_q.rem[46:0];

endmodule // seq_divider

// file: src/fixed_float_arith_unit.sv
`timescale 1ns/1ps
`include "arith_map.svh"

// Operation
// RULE1: all words are signed magnitude; sign one is negative, zero positive
// RULE2: every operand and result word is 48 bits wide
// RULE3: code 65 adds first and second operands into the destination
// RULE4: fixed add or subtract overflow sets overflow flag, wrapped result still written
// RULE5: zero fixed add or subtract result is written with positive sign
// RULE6: code 64 subtracts second operand from first into the destination
// RULE7: code 61 gives high 47 product bits to destination, low 47 to scratch
// RULE8: code 60 gives quotient to destination, remainder with dividend sign to scratch
// RULE9: fixed divide sets overflow when divisor magnitude not above dividend magnitude
// RULE10: code 25 converts a fixed word to floating format
// RULE11: code 66 gives normalized floating difference of first minus second
// RULE12: floating subtract fixes mantissa overflow; exponent overflow stops with flag set
// RULE13: zero mantissa from floating subtract or multiply stores floating zero, underflow
// RULE14: floating subtract normalizes fully unless exponent signs differ and sum exceeds 2047
// RULE15: floating zero is negative all-ones exponent with positive zero mantissa
// RULE16: code 63 gives high product part to destination, low part to scratch
// RULE17: unnormalized or zero floating multiply or divide operand sets non-normalized flag
// RULE18: exponent overflow or underflow on combining terminates with matching flag and value
// RULE19: floating multiply normalizes at most one bit; underflow then stores zero
// RULE20: multiply scratch holds 35 low bits, result sign, unnormalized exponent
// RULE21: code 62 gives quotient and remainder; zero quotient stored as floating zero
// RULE22: floating divide corrects one-bit quotient overflow; exponent overflow flags
// RULE23: divide scratch holds right-justified remainder, dividend sign, zero exponent
module fixed_float_arith_unit
   import arith_pkg::*;
(
   input  wire logic        i_core_clk,
   input  wire logic        i_rst,
   input  wire logic        i_start,
   input  wire logic [5:0]  i_opcode,
   input  wire logic [47:0] i_operand_a,
   input  wire logic [47:0] i_operand_b,
   input  wire logic        i_flag_clear,
   output logic             o_ready,
   output logic             o_done,
   output logic [47:0]      o_result,
   output logic             o_result_we,
   output logic [47:0]      o_scratch,
   output logic             o_scratch_we,
   output logic             o_overflow,
   output logic             o_underflow,
   output logic             o_non_normalized
);

   unit_regs_type r_q;
   unit_regs_type r_d;
   calc_type      c_start;
   calc_type      c_fin;
   logic          div_start;
   logic          div_done;
   logic          div_int;
   logic [46:0]   div_quo;
   logic [46:0]   div_rem;
   logic [46:0]   div_dividend;
   logic [46:0]   div_divisor;
   logic [5:0]    div_steps;

   function automatic logic signed [13:0] exp_of(input logic [11:0] f);
      return f[11] ? -$signed({3'b000, f[10:0]}) : $signed({3'b000, f[10:0]});
   endfunction

   // magnitude beyond 2047 wraps; this is the overflow exponent left behind
   function automatic logic [11:0] pack_exp(input logic signed [13:0] e);
      logic [13:0] m;
      m = (e < 0) ? 14'(-e) : 14'(e);
      return {(e < 0), m[10:0]};
   endfunction

   function automatic logic [5:0] lead_zeros(input logic [46:0] v);
      logic [5:0] n;
      logic       hit;
      n = '0;
      hit = 1'b0;
      for (int i = 46; i >= 0; i--) begin
         if (!hit && !v[i]) begin
            n = n + 6'h01;
         end else begin
            hit = 1'b1;
         end
      end
      return n;
   endfunction

   function automatic logic is_unnorm(input logic [47:0] w);
      return !w[`MANT_MSB] || (w == `FLOAT_ZERO);
   endfunction

   function automatic calc_type float_zero_unf();
      calc_type c;
      c = '0;
      c.result = `FLOAT_ZERO; // RULE15
      c.result_we = 1'b1;
      c.unf = 1'b1;
      return c;
   endfunction

   function automatic calc_type fixed_addsub(input logic [47:0] a, input logic [47:0] b,
                                             input logic sub);
      calc_type    c;
      logic        sb;
      logic        s;
      logic [47:0] sum;
      c = '0;
      sb = b[`SIGN_BIT] ^ sub; // RULE6
      sum = '0;
      s = a[`SIGN_BIT];
      if (a[`SIGN_BIT] == sb) begin // RULE1 RULE3
         sum = {1'b0, a[`MAG_RANGE]} + {1'b0, b[`MAG_RANGE]};
      end else if (a[`MAG_RANGE] >= b[`MAG_RANGE]) begin
         sum = {1'b0, a[`MAG_RANGE] - b[`MAG_RANGE]};
      end else begin
         sum = {1'b0, b[`MAG_RANGE] - a[`MAG_RANGE]};
         s = sb;
      end
      c.ovf = sum[47]; // RULE4
      c.result = {s && (sum[46:0] != '0), sum[46:0]}; // RULE5
      c.result_we = 1'b1;
      return c;
   endfunction

   function automatic calc_type fixed_mul(input logic [47:0] a, input logic [47:0] b);
      calc_type    c;
      logic [93:0] p;
      logic        s;
      c = '0;
      p = {47'h0, a[`MAG_RANGE]} * {47'h0, b[`MAG_RANGE]};
      s = a[`SIGN_BIT] ^ b[`SIGN_BIT];
      c.result = {s && (p[93:47] != '0), p[93:47]}; // RULE7
      c.scratch = {s, p[46:0]}; // RULE7
      c.result_we = 1'b1;
      c.scratch_we = 1'b1;
      return c;
   endfunction

   function automatic calc_type to_float(input logic [47:0] a);
      calc_type    c;
      logic [5:0]  lz;
      logic [46:0] norm;
      c = '0;
      lz = lead_zeros(a[`MAG_RANGE]);
      norm = a[`MAG_RANGE] << lz;
      // fraction form: value is .mantissa times two to the exponent
      c.result = (a[`MAG_RANGE] == '0) ? `FLOAT_ZERO :
                 {a[`SIGN_BIT], pack_exp(`FLT_EXP_BASE - $signed({8'h00, lz})),
                  norm[46:12]}; // RULE10
      c.result_we = 1'b1;
      return c;
   endfunction

   function automatic calc_type float_sub(input logic [47:0] a, input logic [47:0] b);
      calc_type           c;
      logic signed [13:0] ea;
      logic signed [13:0] eb;
      logic signed [13:0] e;
      logic signed [13:0] d;
      logic [35:0]        ma;
      logic [35:0]        mb;
      logic [35:0]        mx;
      logic               sb;
      logic               s;
      logic               skip;
      logic [5:0]         lz;
      c = '0;
      ea = exp_of(a[`EXP_RANGE]);
      eb = exp_of(b[`EXP_RANGE]);
      ma = {1'b0, a[`MANT_RANGE]};
      mb = {1'b0, b[`MANT_RANGE]};
      sb = ~b[`SIGN_BIT]; // RULE11
      lz = '0;
      // alignment truncates the smaller operand; no guard bits are kept
      if (ea >= eb) begin
         e = ea;
         d = ea - eb;
         mb = (d > `ALIGN_LIMIT) ? '0 : mb >> d[5:0];
      end else begin
         e = eb;
         d = eb - ea;
         ma = (d > `ALIGN_LIMIT) ? '0 : ma >> d[5:0];
      end
      s = a[`SIGN_BIT];
      if (a[`SIGN_BIT] == sb) begin
         mx = ma + mb;
      end else if (ma >= mb) begin
         mx = ma - mb;
      end else begin
         mx = mb - ma;
         s = sb;
      end
      skip = (a[`EXP_SIGN_BIT] != b[`EXP_SIGN_BIT]) &&
             (({1'b0, a[`EXP_MAG_RANGE]} + {1'b0, b[`EXP_MAG_RANGE]}) > `EXP_MAG_LIMIT);
      if (mx[35]) begin // RULE12
         mx = mx >> 1;
         e = e + `EXP_ONE;
      end
      if (e > `EXP_MAX) begin // RULE12
         c.ovf = 1'b1;
         c.result = {s, pack_exp(e), mx[34:0]};
         c.result_we = 1'b1;
      end else if (mx == '0) begin
         c = float_zero_unf(); // RULE13
      end else begin
         if (!skip) begin // RULE14
            lz = lead_zeros({mx[34:0], 12'hfff});
            mx = mx << lz;
            e = e - $signed({8'h00, lz});
         end
         if (e < `EXP_MIN) begin
            c = float_zero_unf(); // RULE14
         end else begin
            c.result = {s, pack_exp(e), mx[34:0]};
            c.result_we = 1'b1;
         end
      end
      return c;
   endfunction

   function automatic calc_type float_mul(input logic [47:0] a, input logic [47:0] b);
      calc_type           c;
      logic signed [13:0] e;
      logic signed [13:0] er;
      logic [69:0]        p;
      logic [34:0]        hi;
      logic               s;
      c = '0;
      e = exp_of(a[`EXP_RANGE]) + exp_of(b[`EXP_RANGE]);
      p = {35'h0, a[`MANT_RANGE]} * {35'h0, b[`MANT_RANGE]};
      s = a[`SIGN_BIT] ^ b[`SIGN_BIT];
      er = p[69] ? e : e - `EXP_ONE; // RULE19
      hi = p[69] ? p[69:35] : p[68:34];
      if (e > `EXP_MAX) begin // RULE18
         c.ovf = 1'b1;
         c.result = {1'b0, pack_exp(e), a[`MANT_RANGE]};
         c.result_we = 1'b1;
      end else if (e < `EXP_MIN || p == '0 || er < `EXP_MIN) begin
         c = float_zero_unf(); // RULE13 RULE18 RULE19
      end else begin
         c.result = {s, pack_exp(er), hi}; // RULE16
         c.scratch = {s, pack_exp(e), p[34:0]}; // RULE20
         c.result_we = 1'b1;
         c.scratch_we = 1'b1;
      end
      c.nonnorm = is_unnorm(a) || is_unnorm(b); // RULE17
      return c;
   endfunction

   function automatic calc_type float_div_start(input logic [47:0] a, input logic [47:0] b);
      calc_type           c;
      logic signed [13:0] e;
      c = '0;
      e = exp_of(a[`EXP_RANGE]) - exp_of(b[`EXP_RANGE]);
      if (e > `EXP_MAX) begin // RULE18
         c.ovf = 1'b1;
         c.result = {1'b0, pack_exp(e), a[`MANT_RANGE]};
         c.result_we = 1'b1;
      end else if (e < `EXP_MIN) begin
         c = float_zero_unf(); // RULE18
      end else begin
         c.go_divide = 1'b1;
      end
      c.nonnorm = is_unnorm(a) || is_unnorm(b); // RULE17
      return c;
   endfunction

   function automatic calc_type start_calc(input logic [5:0] op, input logic [47:0] a,
                                           input logic [47:0] b);
      calc_type c;
      c = '0;
      unique case (op)
         `OP_FIXED_ADD:  c = fixed_addsub(a, b, 1'b0); // RULE3
         `OP_FIXED_SUB:  c = fixed_addsub(a, b, 1'b1); // RULE6
         `OP_FIXED_MUL:  c = fixed_mul(a, b);
         `OP_FIXED_DIV:  c.go_divide = 1'b1;
         `OP_BIN_TO_FLT: c = to_float(a);
         `OP_FLOAT_SUB:  c = float_sub(a, b);
         `OP_FLOAT_MUL:  c = float_mul(a, b);
         `OP_FLOAT_DIV:  c = float_div_start(a, b);
         // unknown codes finish with no write and no flag
         default:        c = '0;
      endcase
      return c;
   endfunction

   function automatic calc_type finish_calc(input logic [5:0] op, input logic [47:0] a,
                                            input logic [47:0] b, input logic qint,
                                            input logic [46:0] q, input logic [46:0] rem);
      calc_type           c;
      logic signed [13:0] e;
      logic [34:0]        m;
      logic               s;
      c = '0;
      s = a[`SIGN_BIT] ^ b[`SIGN_BIT];
      e = exp_of(a[`EXP_RANGE]) - exp_of(b[`EXP_RANGE]);
      m = q[34:0];
      c.result_we = 1'b1;
      c.scratch_we = 1'b1;
      if (op == `OP_FIXED_DIV) begin
         c.ovf = qint; // RULE9
         c.result = {s && (q != '0), q}; // RULE8
         c.scratch = {a[`SIGN_BIT], rem}; // RULE8
      end else begin
         if (qint) begin // RULE22
            m = {1'b1, q[34:1]};
            e = e + `EXP_ONE;
         end
         c.ovf = (e > `EXP_MAX) || (qint && (is_unnorm(a) || is_unnorm(b))); // RULE22
         c.result = (m == '0) ? `FLOAT_ZERO : {s, pack_exp(e), m}; // RULE21
         c.scratch = {a[`SIGN_BIT], 12'h000, rem[34:0]}; // RULE23
      end
      return c;
   endfunction

   assign c_start      = start_calc(i_opcode, i_operand_a, i_operand_b);
   assign c_fin        = finish_calc(r_q.op, r_q.a, r_q.b, div_int, div_quo, div_rem);
   assign div_start    = (r_q.state == ST_IDLE) && i_start && c_start.go_divide;
   assign div_dividend = (i_opcode == `OP_FIXED_DIV) ? i_operand_a[`MAG_RANGE] :
                         {12'h000, i_operand_a[`MANT_RANGE]};
   assign div_divisor  = (i_opcode == `OP_FIXED_DIV) ? i_operand_b[`MAG_RANGE] :
                         {12'h000, i_operand_b[`MANT_RANGE]};
   assign div_steps    = (i_opcode == `OP_FIXED_DIV) ? `FIX_DIV_STEPS : `FLT_DIV_STEPS;

   seq_divider u_divider (
      .i_core_clk  (i_core_clk),
      .i_rst       (i_rst),
      .i_start     (div_start),
      .i_dividend  (div_dividend),
      .i_divisor   (div_divisor),
      .i_steps     (div_steps),
      .o_busy      (),
      .o_done      (div_done),
      .o_quotient  (div_quo),
      .o_int_bit   (div_int),
      .o_remainder (div_rem)
   );

   always_comb begin
      calc_type app;
      app = '0;
      r_d = r_q;
      r_d.done = 1'b0;
      unique case (r_q.state)
         ST_IDLE: begin
            if (i_start) begin
               r_d.op = i_opcode;
               r_d.a = i_operand_a;
               r_d.b = i_operand_b;
               app = c_start;
               if (c_start.go_divide) begin
                  r_d.state = ST_DIVIDE;
               end else begin
                  r_d.done = 1'b1;
               end
            end
         end
         ST_DIVIDE: begin
            if (div_done) begin
               app = c_fin;
               r_d.done = 1'b1;
               r_d.state = ST_IDLE;
            end
         end
         default: r_d.state = ST_IDLE;
      endcase
      r_d.result_we = app.result_we;
      r_d.scratch_we = app.scratch_we;
      r_d.result = app.result_we ? app.result : r_q.result; // RULE2
      r_d.scratch = app.scratch_we ? app.scratch : r_q.scratch;
      // a flag raised in the clearing cycle survives the clear
      r_d.ovf = (r_q.ovf && !i_flag_clear) || app.ovf;
      r_d.unf = (r_q.unf && !i_flag_clear) || app.unf;
      r_d.nonnorm = (r_q.nonnorm && !i_flag_clear) || app.nonnorm;
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         r_q <= '0;
         r_q.state <= ST_IDLE;
      end else begin
         r_q <= r_d;
      end
   end

   assign o_ready          = (r_q.state == ST_IDLE);
   assign o_done           = r_q.done;
   assign o_result         = r_q.result;
   assign o_result_we      = r_q.result_we;
   assign o_scratch        = r_q.scratch;
   assign o_scratch_we     = r_q.scratch_we;
   assign o_overflow       = r_q.ovf;
   assign o_underflow      = r_q.unf;
   assign o_non_normalized = r_q.nonnorm;

   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (i_rst);

   wire take   = o_ready && i_start;
   wire is_add = (r_q.op == `OP_FIXED_ADD) || (r_q.op == `OP_FIXED_SUB);
   wire add_ov = (i_operand_a[`SIGN_BIT] == i_operand_b[`SIGN_BIT]) &&
                 (({1'b0, i_operand_a[`MAG_RANGE]} + {1'b0, i_operand_b[`MAG_RANGE]}) >
                  48'h7fffffffffff);

   zero_sign_pos_a: assert property (o_done && is_add && o_result[`MAG_RANGE] == '0 |-> // RULE5
      !o_result[`SIGN_BIT])
      else $error("fixed add zero result negative");
   add_ovf_flag_a: assert property (take && i_opcode == `OP_FIXED_ADD && add_ov |=> // RULE4
      o_overflow && o_result_we)
      else $error("add overflow not flagged");
   // done is registered on the 48th edge after the take, so it is sampled on the 49th
   div_ovf_timing_a: assert property (take && i_opcode == `OP_FIXED_DIV && // RULE9
      i_operand_b[`MAG_RANGE] <= i_operand_a[`MAG_RANGE] |-> ##49 (o_done && o_overflow))
      else $error("fixed divide overflow missing at cycle 48");
   mul_zero_pos_a: assert property (o_done && r_q.op == `OP_FIXED_MUL && // RULE7
      o_result[`MAG_RANGE] == '0 |-> !o_result[`SIGN_BIT])
      else $error("multiply zero result negative");
   rem_sign_a: assert property (o_done && r_q.op == `OP_FIXED_DIV |-> o_scratch_we && // RULE8
      o_scratch[`SIGN_BIT] == r_q.a[`SIGN_BIT])
      else $error("remainder sign not dividend sign");
   fsub_unf_zero_a: assert property (o_done && r_q.op == `OP_FLOAT_SUB && // RULE13
      $rose(o_underflow) |-> o_result == `FLOAT_ZERO)
      else $error("float underflow without floating zero");
   // equal exponents: no shift; after a one-bit shift the scratch exponent is one higher
   fmul_scratch_a: assert property (o_done && r_q.op == `OP_FLOAT_MUL && // RULE20
      o_scratch_we |-> o_scratch[`SIGN_BIT] == o_result[`SIGN_BIT] &&
      (exp_of(o_scratch[`EXP_RANGE]) == exp_of(o_result[`EXP_RANGE]) ||
       (exp_of(o_scratch[`EXP_RANGE]) == exp_of(o_result[`EXP_RANGE]) + `EXP_ONE &&
        o_result[0] == o_scratch[`MANT_MSB])))
      else $error("multiply scratch word inconsistent");
   fdiv_scratch_a: assert property (o_done && r_q.op == `OP_FLOAT_DIV && // RULE23
      o_scratch_we |-> o_scratch[`EXP_RANGE] == 12'h000 && o_scratch[45:35] == '0)
      else $error("divide remainder exponent not zero");
   nonnorm_flag_a: assert property (take && i_opcode == `OP_FLOAT_MUL && // RULE17
      !i_operand_a[`MANT_MSB] |=> o_non_normalized)
      else $error("non-normalized operand not flagged");
   fdiv_latency_a: assert property (div_start && i_opcode == `OP_FLOAT_DIV |=> // RULE21
      !o_done ##36 o_done)
      else $error("float divide not done at cycle 36");

   add_cov_c: cover property (take && i_opcode == `OP_FIXED_ADD ##1 o_overflow);
   fdiv_cov_c: cover property (r_q.state == ST_DIVIDE && r_q.op == `OP_FLOAT_DIV ##1 o_done);
   fsub_cov_c: cover property (o_done && r_q.op == `OP_FLOAT_SUB && !o_underflow);
   fmul_cov_c: cover property (o_done && r_q.op == `OP_FLOAT_MUL && o_scratch_we);

endmodule // fixed_float_arith_unit

// file: testbench/seq_model.sv
`timescale 1ns/1ps
module seq_model (
   input  wire logic        i_core_clk,
   input  wire logic        i_ready,
   output logic             o_start,
   output logic             o_flag_clear,
   output logic [5:0]       o_opcode,
   output logic [47:0]      o_operand_a,
   output logic [47:0]      o_operand_b
);
   initial begin
      {o_start, o_flag_clear, o_opcode, o_operand_a, o_operand_b} = '0;
   end
   // a slow sequencer idles a few cycles; operands never linger once released
   task issue(input logic [5:0] op, input logic [47:0] a, input logic [47:0] b, input int gap);
      repeat (gap) @(negedge i_core_clk);
      do @(negedge i_core_clk); while (i_ready !== 1'b1);
      {o_start, o_flag_clear, o_opcode, o_operand_a, o_operand_b} = {2'b11, op, a, b};
      @(posedge i_core_clk);
      @(negedge i_core_clk);
      {o_start, o_flag_clear, o_operand_a, o_operand_b} = {2'b00, ~a, ~b};
   endtask
endmodule // seq_model

// file: testbench/fixed_float_arith_unit_test.sv
`timescale 1ns/1ps
`include "arith_map.svh"
module fixed_float_arith_unit_test;
   typedef struct packed {
      logic [47:0] r;
      logic [47:0] s;
      logic        cr;
      logic        cs;
      logic [2:0]  f;
   } exp_type;
   logic        clk, rst, start, fclr, ready, done, rwe, swe, ovf, unf, nn;
   logic [5:0]  op;
   logic [47:0] a, b, res, scr, x, y, d;
   logic [63:0] t;
   logic [93:0] p, n, qq, rr;
   exp_type     q[$];
   exp_type     e;
   int          bad_count, tests_run;
   always #4 clk = ~clk;
   fixed_float_arith_unit DUT (.i_core_clk(clk), .i_rst(rst), .i_start(start), .i_opcode(op),
      .i_operand_a(a), .i_operand_b(b), .i_flag_clear(fclr), .o_ready(ready), .o_done(done),
      .o_result(res), .o_result_we(rwe), .o_scratch(scr), .o_scratch_we(swe),
      .o_overflow(ovf), .o_underflow(unf), .o_non_normalized(nn));
   seq_model SEQ (.i_core_clk(clk), .i_ready(ready), .o_start(start), .o_flag_clear(fclr),
      .o_opcode(op), .o_operand_a(a), .o_operand_b(b));
   task cmp_word(input logic [47:0] got, input logic [47:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task cmp_flags(input logic [2:0] got, input logic [2:0] exp);
      cmp_word({45'h0, got}, {45'h0, exp});
   endtask
   // outputs move on the rising edge; look at them half a cycle later
   always @(negedge clk) begin
      if (done === 1'b1) begin
         e = q.pop_front();
         if (e.cr) cmp_word(res, e.r);
         if (e.cs) cmp_word(scr, e.s);
         cmp_flags({ovf, unf, nn}, e.f);
      end
   end
   // signed magnitude sum; a zero comes out with a plus sign
   function automatic logic [47:0] sm_add(input logic [47:0] u, input logic [47:0] v);
      longint s;
      s = (u[47] ? -longint'(u[46:0]) : longint'(u[46:0]))
        + (v[47] ? -longint'(v[46:0]) : longint'(v[46:0]));
      return {s < 0, 47'(s < 0 ? -s : s)};
   endfunction
   task run(input logic [5:0] o, input logic [47:0] u, input logic [47:0] v,
            input logic [47:0] er, input logic [47:0] es, input logic cs, input logic [2:0] f);
      q.push_back('{er, es, o != `OP_FIXED_DIV || f == 3'b000, cs, f});
      SEQ.issue(o, u, v, $urandom_range(0, 2));
      for (int i = 0; i < 60 && done !== 1'b1; i++) @(negedge clk);
   endtask
   task report_and_stop;
      $display("comparisons %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      report_and_stop;
   end
   initial begin
      clk = 1'b0;
      rst = 1'b1;
      void'($urandom(32'h285c));
      repeat (3) @(posedge clk);
      cmp_flags({ready, done, ovf}, 3'b100);
      @(negedge clk);
      rst = 1'b0;
      run(`OP_FIXED_ADD, 48'h7fffffffffff, 48'h7fffffffffff, 48'h7ffffffffffe,
          0, 0, 3'b100);
      run(`OP_FIXED_SUB, 48'h800000001234, 48'h800000001234, 48'h0, 0, 0, 3'b000);
      $display("test fixed boundaries done");
      for (int k = 0; k < 8; k++) begin
         t = {$urandom, $urandom};
         x = {t[63], 2'b00, t[44:0]};
         t = {$urandom, $urandom};
         y = {t[63], 2'b00, t[44:0]};
         d = {y[47], 1'b1, y[45:0]};
         p = 94'(x[46:0]) * 94'(y[46:0]);
         n = {x[46:0], 47'h0};
         qq = n / 94'(d[46:0]);
         rr = n % 94'(d[46:0]);
         run(`OP_FIXED_ADD, x, y, sm_add(x, y), 0, 0, 3'b000);
         run(`OP_FIXED_SUB, x, y, sm_add(x, {~y[47], y[46:0]}), 0, 0, 3'b000);
         run(`OP_FIXED_MUL, x, y, {(x[47] ^ y[47]) & |p[93:47], p[93:47]},
             {x[47] ^ y[47], p[46:0]}, 1, 3'b000);
         run(`OP_FIXED_DIV, x, d, {(x[47] ^ d[47]) & |qq[46:0], qq[46:0]},
             {x[47], rr[46:0]}, 1, 3'b000);
         run(`OP_FIXED_DIV, d, x, 0, 0, 0, 3'b100);
      end
      $display("test fixed random done");
      run(`OP_BIN_TO_FLT, 48'h1, 48'h0, 48'h000c00000000, 0, 0, 3'b000);
      run(`OP_BIN_TO_FLT, 48'h0, 48'h0, `FLOAT_ZERO, 0, 0, 3'b000);
      run(`OP_FLOAT_SUB, 48'h000c00000000, 48'h000c00000000, `FLOAT_ZERO, 0, 0, 3'b010);
      run(`OP_FLOAT_MUL, `FLOAT_ZERO, 48'h000c00000000, `FLOAT_ZERO, 0, 0, 3'b011);
      run(`OP_FLOAT_SUB, 48'h000e00000000, 48'h000c00000000, 48'h000400000000,
          0, 0, 3'b000);
      run(`OP_FLOAT_SUB, 48'h3ffc00000000, 48'hbffc00000000, 48'h000400000000,
          0, 0, 3'b100);
      run(`OP_FLOAT_MUL, 48'h000c00000000, 48'h000c00000000, 48'h000c00000000,
          48'h001000000000, 1, 3'b000);
      run(`OP_FLOAT_DIV, 48'h000c00000000, 48'h000c00000000, 48'h000c00000000,
          48'h0, 1, 3'b000);
      run(`OP_FLOAT_DIV, 48'h000400000000, 48'h000600000000, 48'h000555555555,
          48'h000200000000, 1, 3'b000);
      repeat (3) @(posedge clk);
      cmp_flags(3'(q.size()), 3'b000);
      $display("test float done");
      report_and_stop;
   end
endmodule // fixed_float_arith_unit_test
